// ### logic/fdcsr_pkg.sv
/*
 Holds the constants, types and helper functions shared by the
 floppy controller status block and its read clock divider.
 Assumes nothing of its surroundings beyond a SystemVerilog compiler.

 //Contract
 //- Bit 7 is not-ready, or master reset.
 //- Transfers are refused while drive not ready.
 //- Stepping bit 6 is inverted write protect.
 //- Stepping bit 5 is head load AND timing.
 //- Stepping bit 4 seek error, cleared on update.
 //- Stepping bit 3 is ID checksum error.
 //- Stepping bit 2 is inverted track zero.
 //- Stepping bit 1 is inverted index pulse.
 //- Bit 0 is busy while command executes.
 //- Transfer bit 6 zero on reads, protect on writes.
 //- Read sector bit 5 is deleted-mark flag.
 //- Bit 4 record not found, zero on tracks.
 //- Bit 3 checksum error, zero on tracks.
 //- Transfer bit 2 is lost data, cleared on update.
 //- Transfer bit 1 mirrors data request.
 //- Test mode shows read pulse, read clock.
 //- Timing doubles with the slow clock.
 //- Read clock divides by 8, 16 or 32.
*/
package fdcsr_pkg;

   // Register port map, word offsets
   localparam int          ADDR_W      = 2;
   localparam logic [1:0]  ADDR_STATUS = 2'h0;
   localparam logic [1:0]  ADDR_CTRL   = 2'h1;
   localparam logic [7:0]  CTRL_RESET  = 8'h00;
   localparam logic [7:0]  CTRL_MASK   = 8'h01;
   localparam int          CTRL_SLOW   = 0;

   // Status bit positions
   localparam int S_BUSY  = 0;
   localparam int S_DRQ   = 1;
   localparam int S_LOST  = 2;
   localparam int S_CRC   = 3;
   localparam int S_RNF   = 4;
   localparam int S_HEAD  = 5;
   localparam int S_PROT  = 6;
   localparam int S_NRDY  = 7;

   // Positions of the synchronised drive pins
   localparam int PIN_N      = 10;
   localparam int P_READY    = 0;
   localparam int P_WPROT_N  = 1;
   localparam int P_HLT      = 2;
   localparam int P_TRK0_N   = 3;
   localparam int P_INDEX_N  = 4;
   localparam int P_MRST_N   = 5;
   localparam int P_TEST_N   = 6;
   localparam int P_DENSITY_SELECT_IN_N_N   = 7;
   localparam int P_SIZE8    = 8;
   localparam int P_RDPULSE  = 9;
   localparam logic [PIN_N-1:0] PIN_RESET = 10'h060;

   // Half periods of the derived read clock, in oscillator cycles
   localparam int          DIV_CNT_W = 6;
   localparam logic [5:0]  HALF_DIV8  = 6'h04;
   localparam logic [5:0]  HALF_DIV16 = 6'h08;
   localparam logic [5:0]  HALF_DIV32 = 6'h10;

   typedef enum logic [2:0] {
      CLS_STEP    = 3'b000,
      CLS_RD_ADDR = 3'b001,
      CLS_RD_SECT = 3'b010,
      CLS_RD_TRK  = 3'b011,
      CLS_WR_SECT = 3'b100,
      CLS_WR_TRK  = 3'b101
   } fdcsr_class_e;

   typedef enum logic [1:0] {
      TM_IDLE   = 2'b00,
      TM_ARMED  = 2'b01,
      TM_ACTIVE = 2'b10
   } fdcsr_test_e;

   // True for every sector, address or track transfer class
   function automatic logic isTransfer(input fdcsr_class_e cls);
      return cls != CLS_STEP;
   endfunction

   // True for the two track transfer classes
   function automatic logic isTrack(input fdcsr_class_e cls);
      return (cls == CLS_RD_TRK) || (cls == CLS_WR_TRK);
   endfunction

   // True for write sector and write track
   function automatic logic isWrite(input fdcsr_class_e cls);
      return (cls == CLS_WR_SECT) || (cls == CLS_WR_TRK);
   endfunction

endpackage

// ### logic/fdcsr_read_clock.sv
/*
 Derived read clock divider: oscillator by 8, 16 or 32, doubled on
 the slow clock. Assumes the select inputs are already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
module fdcsr_read_clock #(
   parameter int CNT_W = fdcsr_pkg::DIV_CNT_W
) (
   input  wire logic clk_sys,
   input  wire logic rstn,
   input  wire logic densityN,
   input  wire logic drive8,
   input  wire logic slowClock,
   output var  logic readClk,
   output var  logic readTick
);
   import fdcsr_pkg::*;

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] half;

   // The slow half period doubles 16 to 32 and needs six bits
   if (CNT_W < DIV_CNT_W) begin : g_chk
      $error("fdcsr_read_clock: CNT_W too small");
   end

   // Divide selection, doubled for the slow clock
   always_comb begin
      logic [5:0] h;
      h = HALF_DIV16;
      if (!densityN && drive8) begin
         h = HALF_DIV8;
      end else if (densityN && !drive8) begin
         h = HALF_DIV32;
      end
      if (slowClock) begin
         h = {h[4:0], 1'b0};
      end
      half = CNT_W'(h);
   end

   // Count a half period, then toggle; a select change applies at once
   // to the count in progress, so a short glitch period may follow
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cnt_reg  <= '0;
         readClk  <= 1'b0;
         readTick <= 1'b0;
      end else if (cnt_reg >= half - CNT_W'(1)) begin
         cnt_reg  <= '0;
         readClk  <= ~readClk;
         readTick <= ~readClk;
      end else begin
         cnt_reg  <= cnt_reg + CNT_W'(1);
         readTick <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ### logic/fdcsr_status.sv
/*
 Command_status bank of the floppy formatter/controller, with the
 command acceptance gate, sticky error bits and the test-mode outputs.
 Assumes a command decoder on the same clock that presents command
 starts, completion and error events as one-cycle pulses, and drive
 pins that are asynchronous and synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module fdcsr_status (
   input  wire logic                          clk_sys,
   input  wire logic                          rstn,
   input  wire logic [fdcsr_pkg::ADDR_W-1:0]  regAddr,
   input  wire logic [7:0]                    regWrData,
   input  wire logic                          regWr,
   input  wire logic                          regRd,
   output var  logic [7:0]                    regRdData,
   input  wire logic                          cmdStart,
   input  wire fdcsr_pkg::fdcsr_class_e       cmdClass,
   input  wire logic                          cmdDone,
   output var  logic                          cmdAccepted,
   output var  logic                          cmdRefused,
   input  wire logic                          headLoadOut,
   input  wire logic                          dataRequest,
   input  wire logic                          verifyFailEv,
   input  wire logic                          idCrcEv,
   input  wire logic                          dataCrcEv,
   input  wire logic                          recordNotFoundEv,
   input  wire logic                          lostDataEv,
   input  wire logic                          deletedMarkEv,
   input  wire logic                          writeProtEv,
   input  wire logic                          trackGreaterIn,
   input  wire logic                          stepDirIn,
   input  wire logic                          writeDataIn,
   input  wire logic                          readyIn,
   input  wire logic                          writeProtectInN,
   input  wire logic                          headLoadTimingIn,
   input  wire logic                          trackZeroInN,
   input  wire logic                          indexPulseInN,
   input  wire logic                          masterResetN,
   input  wire logic                          testN,
   input  wire logic                          densitySelectInN,
   input  wire logic                          driveSize8In,
   input  wire logic                          readPulseIn,
   output var  logic                          trackGreaterOut,
   output var  logic                          stepDirOut,
   output var  logic                          writeDataOut,
   output var  logic                          timingDouble,
   output var  logic                          busyOut
);
   import fdcsr_pkg::*;

   logic [PIN_N-1:0] pinMeta_reg;
   logic [PIN_N-1:0] pinSync_reg;
   logic [7:0]       ctrl_reg;
   fdcsr_class_e     class_reg;
   logic             busy_reg;
   logic             seekErr_reg;
   logic             crcErr_reg;
   logic             rnf_reg;
   logic             lost_reg;
   logic             recType_reg;
   logic             wprot_reg;
   fdcsr_test_e      test_reg;
   fdcsr_test_e      test_next;
   logic             notReady;
   logic             mrActive;
   logic             accept;
   logic             refuse;
   logic [7:0]       statusWord;
   logic             readClk;
   logic             readTick;

   // Two flops on every drive pin; only the second stage is read
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pinMeta_reg <= PIN_RESET;
         pinSync_reg <= PIN_RESET;
      end else begin
         pinMeta_reg <= {readPulseIn, driveSize8In, densitySelectInN,
                         testN, masterResetN, indexPulseInN,
                         trackZeroInN, headLoadTimingIn,
                         writeProtectInN, readyIn};
         pinSync_reg <= pinMeta_reg;
      end
   end

   // Not ready is the inverted ready pin, forced by master reset
   assign mrActive = ~pinSync_reg[P_MRST_N];
   assign notReady = ~pinSync_reg[P_READY] | mrActive;

   // A transfer on a not-ready drive never starts
   assign refuse = cmdStart & (busy_reg | mrActive |
                   (isTransfer(cmdClass) & notReady));
   assign accept = cmdStart & ~refuse;

   // Acceptance pulses back to the decoder
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cmdAccepted <= 1'b0;
         cmdRefused  <= 1'b0;
      end else begin
         cmdAccepted <= accept;
         cmdRefused  <= refuse;
      end
   end

   // Layout class is latched only on acceptance
   always_ff @(posedge clk_sys) begin
      if (!rstn || mrActive) begin
         class_reg <= CLS_STEP;
      end else if (accept) begin
         class_reg <= cmdClass;
      end
   end

   // Busy from acceptance to completion
   always_ff @(posedge clk_sys) begin
      if (!rstn || mrActive) begin
         busy_reg <= 1'b0;
         busyOut  <= 1'b0;
      end else begin
         busy_reg <= accept | (busy_reg & ~cmdDone);
         busyOut  <= accept | (busy_reg & ~cmdDone);
      end
   end

   // Sticky error bits, cleared when a new command updates the status.
   // An event in the acceptance cycle survives: set wins over clear.
   always_ff @(posedge clk_sys) begin
      if (!rstn || mrActive) begin
         seekErr_reg <= 1'b0;
         crcErr_reg  <= 1'b0;
         rnf_reg     <= 1'b0;
         lost_reg    <= 1'b0;
         recType_reg <= 1'b0;
         wprot_reg   <= 1'b0;
      end else begin
         seekErr_reg <= (seekErr_reg & ~accept) | verifyFailEv;
         crcErr_reg  <= (crcErr_reg & ~accept) | idCrcEv
                        | dataCrcEv;
         rnf_reg     <= (rnf_reg & ~accept) | recordNotFoundEv;
         lost_reg    <= (lost_reg & ~accept) | lostDataEv;
         recType_reg <= (recType_reg & ~accept) | deletedMarkEv;
         wprot_reg   <= (wprot_reg & ~accept) | writeProtEv;
      end
   end

   // Status composition per class of the last accepted command
   always_comb begin
      statusWord         = 8'h00;
      statusWord[S_NRDY] = notReady;
      statusWord[S_BUSY] = busy_reg;
      case (class_reg)
         CLS_STEP: begin
            statusWord[S_PROT] = ~pinSync_reg[P_WPROT_N];
            statusWord[S_HEAD] = headLoadOut
                                 & pinSync_reg[P_HLT];
            statusWord[S_RNF]  = seekErr_reg;
            statusWord[S_CRC]  = crcErr_reg;
            statusWord[S_LOST] = ~pinSync_reg[P_TRK0_N];
            statusWord[S_DRQ]  = ~pinSync_reg[P_INDEX_N];
         end
         CLS_RD_ADDR,
         CLS_RD_SECT,
         CLS_RD_TRK,
         CLS_WR_SECT,
         CLS_WR_TRK: begin
            // Reads leave bit 6 at zero
            statusWord[S_PROT] = isWrite(class_reg) & wprot_reg;
            // Mark type only on read sector
            statusWord[S_HEAD] = (class_reg == CLS_RD_SECT)
                                 & recType_reg;
            // Track transfers hold bits 4 and 3 at zero
            statusWord[S_RNF]  = ~isTrack(class_reg) & rnf_reg;
            statusWord[S_CRC]  = ~isTrack(class_reg) & crcErr_reg;
            statusWord[S_LOST] = lost_reg;
            statusWord[S_DRQ]  = dataRequest;
         end
         default: begin
            statusWord = 8'h00;
         end
      endcase
   end

   // Control register: slow clock selection
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ctrl_reg <= CTRL_RESET;
      end else if (regWr && regAddr == ADDR_CTRL) begin
         ctrl_reg <= regWrData & CTRL_MASK;
      end
   end

   // Read data stand one cycle only; unmapped offsets read zero
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         regRdData <= 8'h00;
      end else if (regRd && regAddr == ADDR_STATUS) begin
         regRdData <= statusWord;
      end else if (regRd && regAddr == ADDR_CTRL) begin
         regRdData <= ctrl_reg;
      end else begin
         regRdData <= 8'h00;
      end
   end

   // Downstream step-rate logic doubles its intervals on this
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         timingDouble <= 1'b0;
      end else begin
         timingDouble <= ctrl_reg[CTRL_SLOW];
      end
   end

   // Test entry: test high through a master reset, then test low.
   // Reset with test low would stop the oscillator, so it disarms.
   always_comb begin
      test_next = test_reg;
      case (test_reg)
         TM_IDLE: begin
            if (mrActive && !pinSync_reg[P_TEST_N]) begin
               test_next = TM_IDLE;
            end else if (mrActive) begin
               test_next = TM_ARMED;
            end
         end
         TM_ARMED: begin
            if (mrActive && !pinSync_reg[P_TEST_N]) begin
               test_next = TM_IDLE;
            end else if (!mrActive && !pinSync_reg[P_TEST_N]) begin
               test_next = TM_ACTIVE;
            end
         end
         TM_ACTIVE: begin
            if (pinSync_reg[P_TEST_N]) begin
               test_next = TM_IDLE;
            end
         end
         default: begin
            test_next = TM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         test_reg <= TM_IDLE;
      end else begin
         test_reg <= test_next;
      end
   end

   fdcsr_read_clock #(
      .CNT_W     (DIV_CNT_W)
   ) u_read_clock (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .densityN  (pinSync_reg[P_DENSITY_SELECT_IN_N_N]),
      .drive8    (pinSync_reg[P_SIZE8]),
      .slowClock (ctrl_reg[CTRL_SLOW]),
      .readClk   (readClk),
      .readTick  (readTick)
   );

   // Test mode steals the track and direction pins write
   // data pulses once per read clock so its width can be trimmed
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         trackGreaterOut <= 1'b0;
         stepDirOut      <= 1'b0;
         writeDataOut    <= 1'b0;
      end else if (test_reg == TM_ACTIVE) begin
         trackGreaterOut <= pinSync_reg[P_RDPULSE];
         stepDirOut      <= readClk;
         writeDataOut    <= readTick;
      end else begin
         trackGreaterOut <= trackGreaterIn;
         stepDirOut      <= stepDirIn;
         writeDataOut    <= writeDataIn;
      end
   end

   chk_not_ready_read: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      regRd && regAddr == ADDR_STATUS |=>
         regRdData[S_NRDY] == $past(notReady))
      else $error("not ready bit wrong on status read");

   chk_refuse_not_ready: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      cmdStart && isTransfer(cmdClass) && notReady |=>
         cmdRefused && !cmdAccepted && !$changed(class_reg))
      else $error("transfer accepted on a not-ready drive");

   chk_step_head: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      regRd && regAddr == ADDR_STATUS && class_reg == CLS_STEP |=>
         regRdData[S_HEAD] == ($past(headLoadOut) & $past(pinSync_reg[P_HLT])))
      else $error("head loaded bit wrong");

   chk_seek_cleared: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      accept && !verifyFailEv |=> !seekErr_reg)
      else $error("seek error not cleared on update");

   chk_busy_span: assert property (
      @(posedge clk_sys) disable iff (!rstn || mrActive)
      accept ##1 (!cmdDone && !mrActive) |=> statusWord[S_BUSY])
      else $error("busy dropped before completion");

   chk_read_prot_zero: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      regRd && regAddr == ADDR_STATUS && isTransfer(class_reg)
         && !isWrite(class_reg) |=> !regRdData[S_PROT])
      else $error("write protect set on a read");

   chk_track_bits_zero: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      regRd && regAddr == ADDR_STATUS && isTrack(class_reg) |=>
         regRdData[S_RNF:S_CRC] == 2'b00)
      else $error("track transfer shows id errors");

   chk_lost_sticky: assert property (
      @(posedge clk_sys) disable iff (!rstn || mrActive)
      lostDataEv ##1 (!accept && !mrActive) [*2] |->
         lost_reg)
      else $error("lost data did not stick");

   chk_drq_mirror: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      regRd && regAddr == ADDR_STATUS && isTransfer(class_reg) |=>
         regRdData[S_DRQ] == $past(dataRequest))
      else $error("data request bit differs from output");

   chk_test_outputs: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      test_reg == TM_ACTIVE |=>
         stepDirOut == $past(readClk) &&
         trackGreaterOut == $past(pinSync_reg[P_RDPULSE]))
      else $error("test mode outputs not routed");

   chk_class_hold: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      !accept && !mrActive |=> $stable(class_reg))
      else $error("layout class changed without a command");

endmodule
`default_nettype wire

// ### tb/fdcsr_host_model.sv
/*
 Host side model: register bus master plus master reset and test pin
 sequencing. Assumes a free running clk_sys and the bench calling
 its tasks one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module fdcsr_host_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] regRdData,
   output var  logic [1:0] regAddr,
   output var  logic [7:0] regWrData,
   output var  logic       regWr,
   output var  logic       regRd,
   output var  logic       masterResetN,
   output var  logic       testN
);
   // Bus idle and pins inactive from time zero
   initial begin
      regAddr = 2'h0;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      masterResetN = 1'b1;
      testN = 1'b1;
   end

   // One cycle write strobe; the slave never stalls
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1;
      d = regRdData;
   endtask

   // Test stays high across the reset so the oscillator keeps running
   task automatic resetHold();
      @(posedge clk_sys);
      testN <= 1'b1;
      masterResetN <= 1'b0;
   endtask

   task automatic resetRelease();
      @(posedge clk_sys);
      masterResetN <= 1'b1;
   endtask

   // Test low after the strobe enters adjustment, high leaves it
   task automatic setTest(input logic level);
      @(posedge clk_sys);
      testN <= level;
   endtask
endmodule
`default_nettype wire

// ### tb/test_fdc_command_status.sv
/*
 Self-checking bench of the status block: register reads through the
 host model, command gate, sticky bits per class, test mode outputs.
 Assumes the host model for bus and master reset sequencing.
*/
`timescale 1ns/1ps
`default_nettype none
module test_fdc_command_status;
   import fdcsr_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic cmdStart = 1'b0;
   logic cmdDone = 1'b0;
   logic dataRequest = 1'b0;
   fdcsr_class_e cmdClass = CLS_STEP;
   logic [6:0] ev = 7'h00;
   logic head_load_out = 1'b1, readyIn = 1'b1, wpN = 1'b0, head_load_timing_in = 1'b1;
   logic trk0N = 1'b0, idxN = 1'b1, density_select_in_n = 1'b0, size8 = 1'b1;
   logic rdPulse = 1'b0, tgIn = 1'b0, dirIn = 1'b0, wdIn = 1'b0;
   logic [1:0] regAddr;
   logic [7:0] regWrData, regRdData, st, ex;
   logic regWr, regRd, mrN, testN, acc, refd, tgOut, dirOut, wdOut, dbl;
   logic busy;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;

   fdcsr_host_model fdcsr_host_model_i (.clk_sys(clk_sys),
      .regRdData(regRdData), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .masterResetN(mrN), .testN(testN));

   fdcsr_status fdcsr_status_i (.clk_sys(clk_sys), .rstn(rstn),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .cmdStart(cmdStart),
      .cmdClass(cmdClass), .cmdDone(cmdDone), .cmdAccepted(acc),
      .cmdRefused(refd), .headLoadOut(head_load_out), .dataRequest(dataRequest),
      .verifyFailEv(ev[0]), .idCrcEv(ev[1]), .dataCrcEv(ev[2]),
      .recordNotFoundEv(ev[3]), .lostDataEv(ev[4]),
      .deletedMarkEv(ev[5]), .writeProtEv(ev[6]),
      .trackGreaterIn(tgIn), .stepDirIn(dirIn), .writeDataIn(wdIn),
      .readyIn(readyIn), .writeProtectInN(wpN), .headLoadTimingIn(head_load_timing_in),
      .trackZeroInN(trk0N), .indexPulseInN(idxN), .masterResetN(mrN),
      .testN(testN), .densitySelectInN(density_select_in_n), .driveSize8In(size8),
      .readPulseIn(rdPulse), .trackGreaterOut(tgOut),
      .stepDirOut(dirOut), .writeDataOut(wdOut), .timingDouble(dbl),
      .busyOut(busy));

   // 40 MHz system clock
   always #12.5 clk_sys = ~clk_sys;

   // Cut a hang short; the whole run needs about 500 cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         miscompares = miscompares + 1;
         print_verdict();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait4();
      repeat (4) @(posedge clk_sys);
   endtask

   task automatic status(input logic [7:0] exp);
      fdcsr_host_model_i.rd(ADDR_STATUS, st);
      check("status", st, exp);
   endtask

   // Issue a command and see it taken or turned away one cycle later
   task automatic cmd(input logic [2:0] c, input logic ok);
      @(posedge clk_sys);
      cmdStart <= 1'b1;
      cmdClass <= fdcsr_class_e'(c);
      @(posedge clk_sys);
      cmdStart <= 1'b0;
      #1;
      check("accepted", {7'h00, acc}, {7'h00, ok});
      check("refused", {7'h00, refd}, {7'h00, !ok});
   endtask

   task automatic done();
      @(posedge clk_sys);
      cmdDone <= 1'b1;
      @(posedge clk_sys);
      cmdDone <= 1'b0;
      #1;
      check("busy", {7'h00, busy}, 8'h00);
   endtask

   task automatic fire(input logic [6:0] m);
      @(posedge clk_sys);
      ev <= m;
      @(posedge clk_sys);
      ev <= 7'h00;
   endtask

   // Rises of the read clock sampled mid-cycle, second interval timed
   task automatic period(input int exp);
      logic prev;
      logic w;
      int rises, t0, n;
      prev = dirOut;
      rises = 0;
      t0 = 0;
      n = 0;
      w = 1'b0;
      for (int i = 0; i < 400 && rises < 3; i++) begin
         @(negedge clk_sys);
         if (dirOut && !prev) begin
            rises++;
            if (rises == 3) begin
               n = i - t0;
               w = wdOut;
            end
            t0 = i;
         end
         prev = dirOut;
      end
      check("read clock", n[7:0], exp[7:0]);
      check("write pulse", {7'h00, w}, 8'h01);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      wait4();
      status(8'h64);
      @(posedge clk_sys);
      readyIn <= 1'b0;
      wpN <= 1'b1;
      trk0N <= 1'b1;
      idxN <= 1'b0;
      head_load_timing_in <= 1'b0;
      wait4();
      status(8'h82);
      $display("test pins done");
      // Stepping is allowed while not ready, transfers are not
      cmd(3'h2, 1'b0);
      cmd(3'h0, 1'b1);
      cmd(3'h0, 1'b0);
      fire(7'h03);
      status(8'h9B);
      check("busy", {7'h00, busy}, 8'h01);
      done();
      status(8'h9A);
      @(posedge clk_sys);
      readyIn <= 1'b1;
      wpN <= 1'b0;
      trk0N <= 1'b0;
      idxN <= 1'b1;
      head_load_timing_in <= 1'b1;
      wait4();
      cmd(3'h0, 1'b1);
      status(8'h65);
      done();
      $display("test stepping done");
      // Every transfer class with every error event but verify fail and ID checksum raised
      @(posedge clk_sys);
      dataRequest <= 1'b1;
      for (int c = 1; c < 6; c++) begin
         cmd(c[2:0], 1'b1);
         fire(7'h7C);
         ex = {1'b0, c >= 4, c == 2, c != 3 && c != 5, c != 3 && c != 5,
               3'b111};
         status(ex);
         done();
      end
      @(posedge clk_sys);
      dataRequest <= 1'b0;
      wait4();
      status(8'h44);
      $display("test transfers done");
      // Control register, unmapped offset, read-only status
      fdcsr_host_model_i.wr(ADDR_CTRL, 8'h01);
      @(posedge clk_sys);
      #1;
      check("double", {7'h00, dbl}, 8'h01);
      fdcsr_host_model_i.rd(ADDR_CTRL, st);
      check("control", st, 8'h01);
      fdcsr_host_model_i.rd(2'h2, st);
      check("unmapped", st, 8'h00);
      fdcsr_host_model_i.wr(ADDR_STATUS, 8'hFF);
      status(8'h44);
      fdcsr_host_model_i.wr(ADDR_CTRL, 8'h00);
      $display("test registers done");
      // Master reset shows not ready, resets the class, turns commands away
      fdcsr_host_model_i.resetHold();
      wait4();
      status(8'hE4);
      cmd(3'h0, 1'b0);
      fdcsr_host_model_i.resetRelease();
      wait4();
      fdcsr_host_model_i.setTest(1'b0);
      wait4();
      @(posedge clk_sys);
      rdPulse <= 1'b1;
      wait4();
      check("pulse", {7'h00, tgOut}, 8'h01);
      rdPulse <= 1'b0;
      wait4();
      check("pulse", {7'h00, tgOut}, 8'h00);
      period(8);
      @(posedge clk_sys);
      density_select_in_n <= 1'b1;
      period(16);
      @(posedge clk_sys);
      size8 <= 1'b0;
      period(32);
      fdcsr_host_model_i.wr(ADDR_CTRL, 8'h01);
      period(64);
      fdcsr_host_model_i.setTest(1'b1);
      tgIn <= 1'b1;
      dirIn <= 1'b1;
      wait4();
      #1;
      check("normal", {5'h00, tgOut, dirOut, wdOut}, 8'h06);
      $display("test mode done");
      print_verdict();
   end
endmodule
`default_nettype wire
